// ### sss_pkg.sv
package sss_pkg;

    // ************************************************************
    // Sizes of the selection, filter table and audit fields.
    // ************************************************************
    localparam int NUM_PORTS   = 4;
    localparam int SEL_W       = 2;
    localparam int FILT_AW     = 8;
    localparam int FILT_DW     = 2;
    localparam int FILT_WHITE  = 0;
    localparam int FILT_BLACK  = 1;
    localparam int RULE_W      = 4;
    localparam int ID_W        = 8;
    localparam int TIME_W      = 32;
    localparam int EVT_W       = 3;
    localparam int OP_W        = 2;

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [SEL_W-1:0]  SEL_RESET  = 2'h0;
    localparam logic [RULE_W-1:0] RULE_RESET = 4'h0;
    localparam logic [RULE_W-1:0] UCFG_RESET = 4'h0;
    localparam logic [ID_W-1:0]   ID_RESET   = 8'h00;

    // ************************************************************
    // Timing of the authentication device power-off interval.
    // ************************************************************
    localparam int CLK_PERIOD_NS        = 10;
    localparam int AUTH_OFF_TIME_MS     = 1000;
    localparam int AUTH_OFF_CYCLES_DEF  = (AUTH_OFF_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AUTH_CNT_W           = 27;

    // ************************************************************
    // Administrative command codes.
    // ************************************************************
    localparam logic [OP_W-1:0] OP_WHITE_SET = 2'h0;
    localparam logic [OP_W-1:0] OP_BLACK_SET = 2'h1;
    localparam logic [OP_W-1:0] OP_PORT_RULE = 2'h2;

    // ************************************************************
    // Audit event types.
    // ************************************************************
    localparam logic [EVT_W-1:0] EVT_AUDIT_START = 3'h0;
    localparam logic [EVT_W-1:0] EVT_AUDIT_STOP  = 3'h1;
    localparam logic [EVT_W-1:0] EVT_LOGIN       = 3'h2;
    localparam logic [EVT_W-1:0] EVT_LOGOUT      = 3'h3;
    localparam logic [EVT_W-1:0] EVT_FILTER_EDIT = 3'h4;
    localparam logic [EVT_W-1:0] EVT_PORT_RULE   = 3'h5;

    // ************************************************************
    // Supervisor states, Gray coded along the self-test path.
    // ************************************************************
    typedef enum logic [2:0] {
        ST_INTEGRITY = 3'h0,
        ST_ISOLATION = 3'h1,
        ST_CONTROL   = 3'h3,
        ST_TAMPER    = 3'h2,
        ST_NORMAL    = 3'h6,
        ST_DISABLED  = 3'h7
    } sss_state_type;

endpackage

// ### sss_filter_if.sv
`timescale 1ns/100ps
interface sss_filter_if;
    import sss_pkg::*;
    logic               wr_en;
    logic [FILT_AW-1:0] wr_addr;
    logic [FILT_DW-1:0] wr_mask;
    logic [FILT_DW-1:0] wr_data;
    logic               rd_en;
    logic [FILT_AW-1:0] rd_addr;
    logic [FILT_DW-1:0] rd_data;

    modport ctl (output wr_en, output wr_addr, output wr_mask, output wr_data,
                 output rd_en, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_mask, input wr_data,
                 input rd_en, input rd_addr, output rd_data);
endinterface

// ### sss_filter_mem.sv
`timescale 1ns/100ps
module sss_filter_mem
    import sss_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic clk_en,
    sss_filter_if.mem fbus
);

    logic [FILT_DW-1:0] rd_data_reg;

    // ************************************************************
    // One bit plane per mark, so white and black marks edit apart.
    // ************************************************************
    genvar b;
    generate
        for (b = 0; b < FILT_DW; b++) begin : g_bit
            logic plane_mem [2**FILT_AW];
            always_ff @(posedge core_clk) begin
                if (clk_en && fbus.wr_en && fbus.wr_mask[b]) begin
                    plane_mem[fbus.wr_addr] <= fbus.wr_data[b];
                end
            end
            // Registered read; planes are not reset, so program entries before use.
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    rd_data_reg[b] <= 1'b0;
                end else if (clk_en && fbus.rd_en) begin
                    rd_data_reg[b] <= plane_mem[fbus.rd_addr];
                end
            end
        end
    endgenerate

    assign fbus.rd_data = rd_data_reg;

endmodule

// ### sss_supervisor.sv
// Overview of operation
// [R1] Self-test runs at power-up and reset button; the button is ignored once a tamper has been latched.
// [R2] Tests integrity, isolation, selection control, tamper.
// [R3] Failed self-test lights front-panel failure lamp.
// [R4] Selected-computer lamps always valid, including reset.
// [R5] Selection change cuts authentication power one second.
// [R6] Admin actions blocked until admin authenticated.
// [R7] Only authenticated admin edits white and black lists.
// [R8] User configuration needs no authentication.
// [R9] Audit start, stop, login, logout, admin functions.
// [R10] Record holds time, type, subject, outcome.
// [R11] Admin may set per-port data-flow rules.
// [R12] Self-test or tamper failure disables switching.
// [R13] Counter times power-off; connect after expiry.
`timescale 1ns/100ps
module sss_supervisor
    import sss_pkg::*;
#(
    parameter int unsigned AUTH_OFF_CYCLES = AUTH_OFF_CYCLES_DEF
)(
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    input  wire logic                 reset_button,
    input  wire logic                 integrity_ok,
    input  wire logic                 iso_leak,
    input  wire logic                 select_ctrl_ok,
    input  wire logic                 tamper_ok,
    input  wire logic                 tamper_alarm,
    input  wire logic                 sel_req_valid,
    input  wire logic [SEL_W-1:0]     sel_req,
    input  wire logic                 admin_logon_valid,
    input  wire logic [ID_W-1:0]      admin_id,
    input  wire logic                 admin_pass_ok,
    input  wire logic                 admin_key_ok,
    input  wire logic                 admin_logout,
    input  wire logic                 cmd_valid,
    input  wire logic [OP_W-1:0]      cmd_op,
    input  wire logic [FILT_AW-1:0]   cmd_index,
    input  wire logic [RULE_W-1:0]    cmd_data,
    input  wire logic                 user_cfg_valid,
    input  wire logic [RULE_W-1:0]    user_cfg_data,
    input  wire logic                 lookup_valid,
    input  wire logic [FILT_AW-1:0]   lookup_code,
    input  wire logic [TIME_W-1:0]    rtc_time,
    output logic                      selftest_active,
    output logic                      iso_probe_en,
    output logic                      led_fail,
    output logic                      led_ok,
    output logic [NUM_PORTS-1:0]      led_select,
    output logic                      switching_enabled,
    output logic                      auth_power_en,
    output logic [NUM_PORTS-1:0]      auth_port_en,
    output logic                      admin_active,
    output logic                      cmd_done,
    output logic                      cmd_refused,
    output logic [NUM_PORTS*RULE_W-1:0] port_rules,
    output logic [RULE_W-1:0]         user_cfg,
    output logic                      lookup_done,
    output logic                      lookup_allowed,
    output logic                      audit_valid,
    output logic [TIME_W-1:0]         audit_time,
    output logic [EVT_W-1:0]          audit_event,
    output logic [ID_W-1:0]           audit_subject,
    output logic                      audit_success
);

    // ************************************************************
    // Helpers and declarations.
    // ************************************************************
    function automatic logic [NUM_PORTS-1:0] sss_onehot(input logic [SEL_W-1:0] s);
        logic [NUM_PORTS-1:0] v;
        v = '0;
        v[s] = 1'b1;
        return v;
    endfunction

    localparam logic [AUTH_CNT_W-1:0] AUTH_LOAD = AUTH_CNT_W'(AUTH_OFF_CYCLES - 1);

    sss_state_type            state_reg, state_next;
    logic                     button_prev_reg;
    logic                     tamper_latch_reg;
    logic [SEL_W-1:0]         sel_reg;
    logic [AUTH_CNT_W-1:0]    auth_cnt_reg;
    logic                     auth_off_reg;
    logic [NUM_PORTS-1:0]     auth_port_reg;
    logic                     admin_reg;
    logic [ID_W-1:0]          admin_id_reg;
    logic                     cmd_done_reg, cmd_refused_reg;
    logic [RULE_W-1:0]        user_cfg_reg;
    logic                     lookup_done_reg;
    logic                     audit_valid_reg, audit_success_reg;
    logic [TIME_W-1:0]        audit_time_reg;
    logic [EVT_W-1:0]         audit_event_reg;
    logic [ID_W-1:0]          audit_subject_reg;
    logic                     button_rise, tamper_hit, normal, leaving, entering;
    logic                     op_ok, logon_evt, logout_evt, cmd_evt, cmd_legal, cmd_filter;
    logic                     sel_change;

    sss_filter_if fbus ();

    assign button_rise = reset_button & ~button_prev_reg;
    assign normal      = (state_reg == ST_NORMAL);
    assign tamper_hit  = (normal & tamper_alarm) | ((state_reg == ST_TAMPER) & ~tamper_ok);

    // ************************************************************
    // Self-test sequence and secure disabled state.
    // ************************************************************
    // A latched tamper keeps the unit disabled; the button cannot revive it.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_INTEGRITY: state_next = integrity_ok ? ST_ISOLATION : ST_DISABLED;  // [R2]
            ST_ISOLATION: state_next = iso_leak ? ST_DISABLED : ST_CONTROL;         // [R2]
            ST_CONTROL:   state_next = select_ctrl_ok ? ST_TAMPER : ST_DISABLED;    // [R2]
            ST_TAMPER:    state_next = tamper_ok ? ST_NORMAL : ST_DISABLED;         // [R12]
            ST_NORMAL:    state_next = ST_NORMAL;
            ST_DISABLED:  state_next = ST_DISABLED;                                 // [R12]
            default:      state_next = ST_DISABLED;
        endcase
        if (tamper_hit) begin
            state_next = ST_DISABLED;  // [R12]
        end else if (button_rise && !tamper_latch_reg) begin
            state_next = ST_INTEGRITY;  // [R1]
        end
    end

    // Reset starts the suite so no switching happens before it passes.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg       <= ST_INTEGRITY;  // [R1]
            button_prev_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg       <= state_next;
            button_prev_reg <= reset_button;
        end
    end

    // Tamper evidence is sticky until the next power-on reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tamper_latch_reg <= 1'b0;
        end else if (clk_en && tamper_hit) begin
            tamper_latch_reg <= 1'b1;  // [R12]
        end
    end

    assign selftest_active   = !normal && (state_reg != ST_DISABLED);
    assign iso_probe_en      = (state_reg == ST_ISOLATION);
    assign led_fail          = (state_reg == ST_DISABLED);  // [R3]
    assign led_ok            = normal;
    assign switching_enabled = normal;  // [R12]

    // ************************************************************
    // Selection, indication and authentication device power.
    // ************************************************************
    assign sel_change = normal & sel_req_valid & (sel_req != sel_reg);

    // The lamps follow the held selection, which has a reset value.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_reg <= SEL_RESET;
        end else if (clk_en && sel_change) begin
            sel_reg <= sel_req;
        end
    end

    assign led_select = sss_onehot(sel_reg);  // [R4]

    // Power drops on every change; a change during the interval restarts it,
    // so the device is never reconnected early.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            auth_off_reg <= 1'b0;
            auth_cnt_reg <= '0;
        end else if (clk_en) begin
            if (sel_change) begin
                auth_off_reg <= 1'b1;       // [R5]
                auth_cnt_reg <= AUTH_LOAD;  // [R13]
            end else if (auth_off_reg) begin
                if (auth_cnt_reg == '0) begin
                    auth_off_reg <= 1'b0;  // [R13]
                end else begin
                    auth_cnt_reg <= auth_cnt_reg - 1'b1;
                end
            end
        end
    end

    // Connection to the new computer only after the counter has expired.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            auth_port_reg <= '0;
        end else if (clk_en) begin
            auth_port_reg <= (normal && !auth_off_reg && !sel_change) ? sss_onehot(sel_reg) : '0;  // [R13]
        end
    end

    assign auth_power_en = ~auth_off_reg;  // [R5]
    assign auth_port_en  = auth_port_reg;

    // ************************************************************
    // Administrator session and management commands.
    // ************************************************************
    // One admin request per cycle: logon beats logout beats a command.
    assign leaving    = normal & (state_next != ST_NORMAL);
    assign entering   = !normal & (state_next == ST_NORMAL);
    assign op_ok      = normal & ~leaving;
    assign logon_evt  = op_ok & admin_logon_valid;
    assign logout_evt = op_ok & ~admin_logon_valid & admin_logout & admin_reg;
    assign cmd_evt    = op_ok & ~admin_logon_valid & ~admin_logout & cmd_valid;
    assign cmd_filter = (cmd_op == OP_WHITE_SET) || (cmd_op == OP_BLACK_SET);
    assign cmd_legal  = admin_reg && (cmd_filter || (cmd_op == OP_PORT_RULE));  // [R6]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            admin_reg    <= 1'b0;
            admin_id_reg <= ID_RESET;
        end else if (clk_en) begin
            if (!op_ok || logout_evt) begin
                admin_reg <= 1'b0;
            end else if (logon_evt) begin
                admin_reg    <= admin_pass_ok | admin_key_ok;  // [R6]
                admin_id_reg <= admin_id;
            end
        end
    end

    assign admin_active = admin_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd_done_reg    <= 1'b0;
            cmd_refused_reg <= 1'b0;
        end else if (clk_en) begin
            cmd_done_reg    <= cmd_evt & cmd_legal;
            cmd_refused_reg <= cmd_evt & ~cmd_legal;  // [R7]
        end
    end

    assign cmd_done    = cmd_done_reg;
    assign cmd_refused = cmd_refused_reg;

    // List edits reach the table only for an authenticated administrator.
    assign fbus.wr_en   = cmd_evt & cmd_legal & cmd_filter;  // [R7]
    assign fbus.wr_addr = cmd_index;
    assign fbus.wr_mask = (cmd_op == OP_BLACK_SET) ? 2'h2 : 2'h1;
    assign fbus.wr_data = {cmd_data[0], cmd_data[0]};
    assign fbus.rd_en   = lookup_valid;
    assign fbus.rd_addr = lookup_code;

    // Per-port data-flow rules, one register for each computer port.
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_rule
            logic [RULE_W-1:0] rule_reg;
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    rule_reg <= RULE_RESET;
                end else if (clk_en && cmd_evt && cmd_legal && cmd_op == OP_PORT_RULE &&
                             cmd_index[SEL_W-1:0] == SEL_W'(p)) begin
                    rule_reg <= cmd_data;  // [R11]
                end
            end
            assign port_rules[p*RULE_W +: RULE_W] = rule_reg;
        end
    endgenerate

    // User settings are open to anyone, with no session check.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            user_cfg_reg <= UCFG_RESET;
        end else if (clk_en && user_cfg_valid) begin
            user_cfg_reg <= user_cfg_data;  // [R8]
        end
    end

    assign user_cfg = user_cfg_reg;

    // ************************************************************
    // Device qualification lookup.
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lookup_done_reg <= 1'b0;
        end else if (clk_en) begin
            lookup_done_reg <= lookup_valid;
        end
    end

    assign lookup_done    = lookup_done_reg;
    assign lookup_allowed = lookup_done_reg & fbus.rd_data[FILT_WHITE] & ~fbus.rd_data[FILT_BLACK];

    sss_filter_mem u_filter (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .fbus     (fbus.mem)
    );

    // ************************************************************
    // Audit record generation.
    // ************************************************************
    // Stop and start take precedence; admin traffic is held off in those cycles.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            audit_valid_reg   <= 1'b0;
            audit_time_reg    <= '0;
            audit_event_reg   <= EVT_AUDIT_START;
            audit_subject_reg <= ID_RESET;
            audit_success_reg <= 1'b0;
        end else if (clk_en) begin
            audit_valid_reg   <= leaving | entering | logon_evt | logout_evt | (cmd_evt & cmd_filter) |
                                 (cmd_evt & cmd_op == OP_PORT_RULE);  // [R9]
            audit_time_reg    <= rtc_time;  // [R10]
            audit_subject_reg <= logon_evt ? admin_id : admin_id_reg;
            audit_success_reg <= 1'b1;
            if (leaving) begin
                audit_event_reg <= EVT_AUDIT_STOP;
                audit_subject_reg <= ID_RESET;
            end else if (entering) begin
                audit_event_reg <= EVT_AUDIT_START;
                audit_subject_reg <= ID_RESET;
            end else if (logon_evt) begin
                audit_event_reg   <= EVT_LOGIN;
                audit_success_reg <= admin_pass_ok | admin_key_ok;  // [R10]
            end else if (logout_evt) begin
                audit_event_reg <= EVT_LOGOUT;
            end else begin
                audit_event_reg   <= cmd_filter ? EVT_FILTER_EDIT : EVT_PORT_RULE;
                audit_success_reg <= cmd_legal;
            end
        end
    end

    assign audit_valid   = audit_valid_reg;
    assign audit_time    = audit_time_reg;
    assign audit_event   = audit_event_reg;
    assign audit_subject = audit_subject_reg;
    assign audit_success = audit_success_reg;

endmodule

// ### sss_selftest_model.sv
`timescale 1ns/100ps
module sss_selftest_model (
    input  wire logic       core_clk,
    input  wire logic       iso_probe_en,
    input  wire logic [2:0] fail_stage,
    output logic            integrity_ok,
    output logic            iso_leak,
    output logic            select_ctrl_ok,
    output logic            tamper_ok
);
    logic wiggle_reg = 1'h0;
    // An idle leak line wiggles, so sampling it outside the isolation stage cannot pass by luck.
    always_ff @(posedge core_clk) begin
        wiggle_reg <= ~wiggle_reg;
    end
    // Each responder passes unless the bench orders its stage to fail.
    assign integrity_ok   = fail_stage != 3'h1;
    assign iso_leak       = iso_probe_en ? fail_stage == 3'h2 : wiggle_reg;
    assign select_ctrl_ok = fail_stage != 3'h3;
    assign tamper_ok      = fail_stage != 3'h4;
endmodule

// ### sss_monitor.sv
`timescale 1ns/100ps
module sss_monitor
    import sss_pkg::*;
#(
    parameter int unsigned AUTH_OFF_CYCLES = 20
)(
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire logic                 clk_en,
    input wire logic                 user_cfg_valid,
    input wire logic [RULE_W-1:0]    user_cfg_data,
    input wire logic                 selftest_active,
    input wire logic                 led_fail,
    input wire logic                 led_ok,
    input wire logic [NUM_PORTS-1:0] led_select,
    input wire logic                 switching_enabled,
    input wire logic                 auth_power_en,
    input wire logic [NUM_PORTS-1:0] auth_port_en,
    input wire logic                 admin_active,
    input wire logic                 cmd_done,
    input wire logic [RULE_W-1:0]    user_cfg,
    input wire logic                 audit_valid,
    input wire logic [EVT_W-1:0]     audit_event
);
    // ********
    // Checks
    // ********
    int unsigned off_cnt;
    // Reset loads a full count, so the power return that reset forces is not judged short.
    always_ff @(posedge core_clk) begin
        off_cnt <= rst ? AUTH_OFF_CYCLES : (auth_power_en ? 0 : off_cnt + 1);
    end
    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sel_onehot_a: assert property ($onehot(led_select))
        else $error("selection lamps not one-hot");
    lamp_state_a: assert property (!(led_ok && led_fail) && switching_enabled == led_ok)
        else $error("lamps and switching disagree");
    off_len_a: assert property ($rose(auth_power_en) |-> off_cnt >= AUTH_OFF_CYCLES)
        else $error("authentication power back too early");
    port_dark_a: assert property (!auth_power_en |-> auth_port_en == '0)
        else $error("port joined while unpowered");
    port_join_a: assert property ($rose(auth_power_en) && !$past(rst) && led_ok |=> auth_port_en == led_select)
        else $error("port not joined after power return");
    done_auth_a: assert property (cmd_done |-> $past(admin_active))
        else $error("command done without session");
    cfg_open_a: assert property (user_cfg_valid && clk_en |=> user_cfg == $past(user_cfg_data))
        else $error("user setting not taken");
    start_rec_a: assert property ($rose(led_ok) |-> audit_valid && audit_event == EVT_AUDIT_START
        && $past(selftest_active)) else $error("no start record on entering service");
endmodule
bind sss_supervisor sss_monitor #(.AUTH_OFF_CYCLES(AUTH_OFF_CYCLES)) mon_u (.core_clk, .rst, .clk_en,
    .user_cfg_valid, .user_cfg_data, .selftest_active, .led_fail, .led_ok, .led_select, .switching_enabled,
    .auth_power_en, .auth_port_en, .admin_active, .cmd_done, .user_cfg, .audit_valid, .audit_event);

// ### switch_security_supervisor_tb_top.sv
`timescale 1ns/100ps
module switch_security_supervisor_tb_top;
    import sss_pkg::*;
    // ********
    // Bench
    // ********
    localparam int N = 20;
    logic        core_clk = '0, rst = '1, clk_en = '1, reset_button = '0, tamper_alarm = '0;
    logic        sel_req_valid = '0, admin_logon_valid = '0, admin_pass_ok = '0, admin_key_ok = '0;
    logic        admin_logout = '0, cmd_valid = '0, user_cfg_valid = '0, lookup_valid = '0;
    logic [1:0]  sel_req = '0, cmd_op = '0;
    logic [2:0]  fail_stage = '0, audit_event;
    logic [3:0]  cmd_data = '0, user_cfg_data = '0, led_select, auth_port_en, user_cfg;
    logic [7:0]  admin_id = '0, cmd_index = '0, lookup_code = 8'h3C, audit_subject;
    logic [15:0] port_rules;
    logic [31:0] rtc_time = 32'h0000_0100, audit_time;
    logic        integrity_ok, iso_leak, select_ctrl_ok, tamper_ok, selftest_active, iso_probe_en;
    logic        led_fail, led_ok, switching_enabled, auth_power_en, admin_active, cmd_done;
    logic        cmd_refused, lookup_done, lookup_allowed, audit_valid, audit_success;
    int          err_total = 0, comparisons = 0;
    // A short off interval keeps the run brief; expectations follow N.
    sss_supervisor #(.AUTH_OFF_CYCLES(N)) dut_u (.core_clk, .rst, .clk_en, .reset_button, .integrity_ok,
        .iso_leak, .select_ctrl_ok, .tamper_ok, .tamper_alarm, .sel_req_valid, .sel_req, .admin_logon_valid,
        .admin_id, .admin_pass_ok, .admin_key_ok, .admin_logout, .cmd_valid, .cmd_op, .cmd_index, .cmd_data,
        .user_cfg_valid, .user_cfg_data, .lookup_valid, .lookup_code, .rtc_time, .selftest_active,
        .iso_probe_en, .led_fail, .led_ok, .led_select, .switching_enabled, .auth_power_en, .auth_port_en,
        .admin_active, .cmd_done, .cmd_refused, .port_rules, .user_cfg, .lookup_done, .lookup_allowed,
        .audit_valid, .audit_time, .audit_event, .audit_subject, .audit_success);
    sss_selftest_model env_u (.core_clk, .iso_probe_en, .fail_stage, .integrity_ok, .iso_leak,
        .select_ctrl_ok, .tamper_ok);
    initial forever #5 core_clk = ~core_clk;
    // The whole sequence needs about ninety cycles; two thousand means a hang.
    initial begin
        #20000;
        err_total++;
        wrap_up();
    end
    task automatic tk(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // One idle cycle first, so a pulse never rises in the step where the last one fell.
    task automatic pulse(ref logic s);
        tk(1);
        s = 1'h1;
        tk(1);
        s = 1'h0;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic boot();
        rst = 1'h1;
        tk(2);
        rst = 1'h0;
        chk("sel_reset", 4'h1, led_select);
        chk("testing", 1'h1, selftest_active);
        tk(4);
        chk("ok_lamp", fail_stage == 3'h0, led_ok);
        chk("fail_lamp", fail_stage != 3'h0, led_fail);
    endtask
    task automatic t_select();
        sel_req = 2'h2;
        pulse(sel_req_valid);
        chk("sel_lamp", 4'h4, led_select);
        chk("pwr_off", 1'h0, auth_power_en);
        tk(N - 1);
        chk("pwr_hold", 1'h0, auth_power_en);
        tk(1);
        chk("pwr_back", 1'h1, auth_power_en);
        tk(1);
        chk("port_join", 4'h4, auth_port_en);
        pulse(sel_req_valid);
        chk("same_port", 1'h1, auth_power_en);
    endtask
    task automatic cmd(input logic [1:0] op, input logic [3:0] d, input logic ok);
        cmd_op = op;
        cmd_data = d;
        pulse(cmd_valid);
        chk("cmd_done", ok, cmd_done);
        chk("cmd_refused", !ok, cmd_refused);
        chk("cmd_audit", ok, audit_success);
        chk("cmd_evt", op == OP_PORT_RULE ? EVT_PORT_RULE : EVT_FILTER_EDIT, audit_event);
    endtask
    task automatic t_admin();
        cmd_index = 8'h3C;
        cmd(OP_WHITE_SET, 4'h1, 1'h0);
        pulse(admin_logon_valid);
        chk("no_pass", 1'h0, admin_active);
        admin_id = 8'h5A;
        admin_key_ok = 1'h1;
        rtc_time = 32'h0000_7A11;
        pulse(admin_logon_valid);
        chk("admin_on", 1'h1, admin_active);
        chk("login_evt", EVT_LOGIN, audit_event);
        chk("login_id", 8'h5A, audit_subject);
        chk("login_time", 32'h0000_7A11, audit_time);
        cmd(OP_BLACK_SET, 4'h0, 1'h1);
        cmd(OP_WHITE_SET, 4'h1, 1'h1);
        pulse(lookup_valid);
        chk("lookup_done", 1'h1, lookup_done);
        chk("lookup", 1'h1, lookup_allowed);
        cmd_index = 8'h02;
        cmd(OP_PORT_RULE, 4'hA, 1'h1);
        pulse(admin_logout);
        chk("logout_evt", EVT_LOGOUT, audit_event);
        cmd(OP_PORT_RULE, 4'h5, 1'h0);
        chk("rule_kept", 4'hA, port_rules[11:8]);
    endtask
    task automatic t_ucfg();
        user_cfg_data = 4'h9;
        pulse(user_cfg_valid);
        chk("user_cfg", 4'h9, user_cfg);
    endtask
    // Tamper must stick: the button may not bring the switch back.
    task automatic t_tamper();
        pulse(tamper_alarm);
        chk("tamper_off", 1'h1, led_fail);
        chk("stop_evt", EVT_AUDIT_STOP, audit_event);
        pulse(reset_button);
        tk(5);
        chk("tamper_lock", 1'h0, switching_enabled);
    endtask
    task automatic t_fail();
        for (int s = 4; s >= 1; s--) begin
            fail_stage = 3'(s);
            boot();
        end
        fail_stage = 3'h0;
        pulse(reset_button);
        tk(4);
        chk("retest", 1'h1, led_ok);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        boot();
        t_select();
        t_admin();
        t_ucfg();
        t_tamper();
        t_fail();
        wrap_up();
    end
endmodule
